// ---- logic/spbc_defines.svh ----
`ifndef SPBC_DEFINES_SVH
`define SPBC_DEFINES_SVH

// ==========================================================
// Time base
`define SPBC_CLK_PERIOD_NS    4
`define SPBC_TICK_NS          10000000
`define SPBC_TICK_CYCLES      (`SPBC_TICK_NS / `SPBC_CLK_PERIOD_NS)

// ==========================================================
// Register byte offsets
`define SPBC_OFS_CTRL         8'h00
`define SPBC_OFS_TRAVERSE     8'h04
`define SPBC_OFS_CLOSE_LEN    8'h08
`define SPBC_OFS_OPEN_LEN     8'h0c
`define SPBC_OFS_TERM         8'h10
`define SPBC_OFS_FTRIP_LEN    8'h14
`define SPBC_OFS_STATUS       8'h18
`define SPBC_OFS_EVENTS       8'h1c

// ==========================================================
// Control field positions
`define SPBC_CTRL_SYNC_EN     0
`define SPBC_CTRL_READY_EN    1
`define SPBC_CTRL_READY_HIGH  2

// ==========================================================
// Event field positions
`define SPBC_EV_OPEN_TMO      0
`define SPBC_EV_CLOSE_TMO     1
`define SPBC_EV_CLOSE_REFUSED 2
`define SPBC_EV_BUSY_IGNORED  3

// ==========================================================
// Reset values, times in 10 ms ticks
`define SPBC_RST_CTRL         3'h0
`define SPBC_RST_TRAVERSE     16'h0014
`define SPBC_RST_CLOSE_LEN    16'h0014
`define SPBC_RST_OPEN_LEN     16'h0014
`define SPBC_RST_TERM         16'h03e8
`define SPBC_RST_FTRIP_LEN    16'h0014

`endif

// ---- logic/spbc_pkg.sv ----
`default_nettype none

// ==========================================================
// Shared types
package spbc_pkg;

   // Position code of one phase or of the cart
   typedef enum logic [1:0] {
      POS_MID,
      POS_OPEN,
      POS_CLOSED,
      POS_BAD
   } spbc_pos_e;

   // Control operation in progress
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_OPENING,
      ST_CLOSING
   } spbc_state_e;

endpackage : spbc_pkg

`default_nettype wire

// ---- logic/spbc_in_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Three-stage input synchroniser with agreement filter
module spbc_in_sync #(
   parameter int W = 10
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic val_ff;

         // Shift chain, first stage read only by the second
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
               s3_ff <= 1'b0;
            end else begin
               s1_ff <= pin_in[i];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
            end
         end

         // Accept a level once stages two and three agree
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               val_ff <= 1'b0;
            end else if (s2_ff == s3_ff) begin
               val_ff <= s3_ff;
            end
         end

         assign pin_out[i] = val_ff;
      end
   endgenerate

endmodule : spbc_in_sync

`default_nettype wire

// ---- logic/spbc_breaker_ctrl.sv ----
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spbc_defines.svh"

module spbc_breaker_ctrl #(
   parameter int TICK_CYCLES = `SPBC_TICK_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [2:0]  open_status_in,
   input  wire logic [2:0]  close_status_in,
   input  wire logic        cart_inserted_input,
   input  wire logic        cart_removed_input,
   input  wire logic        ready_in,
   input  wire logic        sync_in,
   input  wire logic [2:0]  open_req,
   input  wire logic        close_req,
   input  wire logic        ar_in_control,
   input  wire logic        ar_reclose_expected,
   output logic      [2:0]  open_cmd_out,
   output logic             close_cmd_out,
   output logic             final_trip_out,
   output logic      [5:0]  phase_status,
   output logic      [1:0]  cart_status,
   output logic             ctrl_timeout_event,
   output logic             close_refused_event
);

   // ==========================================================
   // Position decode
   function automatic spbc_pkg::spbc_pos_e pos_decode(input logic opn, input logic cls);
      spbc_pkg::spbc_pos_e p;
      p = spbc_pkg::POS_MID;
      case ({opn, cls})
         2'b10:   p = spbc_pkg::POS_OPEN;
         2'b01:   p = spbc_pkg::POS_CLOSED;
         2'b11:   p = spbc_pkg::POS_BAD;
         default: p = spbc_pkg::POS_MID;
      endcase
      return p;
   endfunction : pos_decode

   // ==========================================================
   // Field input synchronisation
   logic [9:0] pins_s;
   logic [2:0] open_s;
   logic [2:0] close_s;
   logic       cart_in_s;
   logic       cart_out_s;
   logic       ready_s;
   logic       sync_s;

   spbc_in_sync #(.W(10)) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin_in  ({sync_in, ready_in, cart_removed_input, cart_inserted_input,
                 close_status_in, open_status_in}),
      .pin_out (pins_s)
   );

   assign open_s     = pins_s[2:0];
   assign close_s    = pins_s[5:3];
   assign cart_in_s  = pins_s[6];
   assign cart_out_s = pins_s[7];
   assign ready_s    = pins_s[8];
   assign sync_s     = pins_s[9];

   // ==========================================================
   // Settings registers
   logic [2:0]  ctrl_ff;
   logic [15:0] traverse_ff;
   logic [15:0] close_len_ff;
   logic [15:0] open_len_ff;
   logic [15:0] term_ff;
   logic [15:0] ftrip_len_ff;

   // Software writes to settings
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff      <= `SPBC_RST_CTRL;
         traverse_ff  <= `SPBC_RST_TRAVERSE;
         close_len_ff <= `SPBC_RST_CLOSE_LEN;
         open_len_ff  <= `SPBC_RST_OPEN_LEN;
         term_ff      <= `SPBC_RST_TERM;
         ftrip_len_ff <= `SPBC_RST_FTRIP_LEN;
      end else if (reg_wr) begin
         case (reg_addr)
            `SPBC_OFS_CTRL:      ctrl_ff      <= reg_wdata[2:0];
            `SPBC_OFS_TRAVERSE:  traverse_ff  <= reg_wdata[15:0];
            `SPBC_OFS_CLOSE_LEN: close_len_ff <= reg_wdata[15:0];
            `SPBC_OFS_OPEN_LEN:  open_len_ff  <= reg_wdata[15:0];
            `SPBC_OFS_TERM:      term_ff      <= reg_wdata[15:0];
            `SPBC_OFS_FTRIP_LEN: ftrip_len_ff <= reg_wdata[15:0];
            default:             ;
         endcase
      end
   end

   // ==========================================================
   // Common time base
   logic [23:0] tick_cnt_ff;
   logic        tick;

   assign tick = (tick_cnt_ff == 24'(TICK_CYCLES - 1));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_cnt_ff <= 24'h000000;
      end else if (tick) begin
         tick_cnt_ff <= 24'h000000;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 24'h000001;
      end
   end

   // ==========================================================
   // Per-phase status with traverse filtering
   logic [2:0] ph_open;
   logic [2:0] ph_closed;

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_phase
         spbc_pkg::spbc_pos_e raw;
         spbc_pkg::spbc_pos_e raw_q_ff;
         spbc_pkg::spbc_pos_e stat_ff;
         logic [15:0]         trav_cnt_ff;

         assign raw = pos_decode(open_s[i], close_s[i]);

         // Time spent in the present raw code
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               raw_q_ff    <= spbc_pkg::POS_MID;
               trav_cnt_ff <= 16'h0000;
            end else begin
               raw_q_ff <= raw;
               if (raw != raw_q_ff) begin
                  trav_cnt_ff <= 16'h0000;
               end else if (tick && trav_cnt_ff != 16'hffff) begin
                  trav_cnt_ff <= trav_cnt_ff + 16'h0001;
               end
            end
         end

         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               stat_ff <= spbc_pkg::POS_MID;
            end else if (raw == spbc_pkg::POS_OPEN || raw == spbc_pkg::POS_CLOSED) begin
               stat_ff <= raw;
            end else if (raw == raw_q_ff && trav_cnt_ff >= traverse_ff) begin
               stat_ff <= raw;
            end
         end

         assign phase_status[2*i +: 2] = stat_ff;
         assign ph_open[i]             = (stat_ff == spbc_pkg::POS_OPEN);
         assign ph_closed[i]           = (stat_ff == spbc_pkg::POS_CLOSED);
      end
   endgenerate

   // ==========================================================
   // Cart position
   spbc_pkg::spbc_pos_e cart_ff;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cart_ff <= spbc_pkg::POS_MID;
      end else begin
         cart_ff <= pos_decode(cart_out_s, cart_in_s);
      end
   end

   assign cart_status = cart_ff;

   // ==========================================================
   // Control operation
   spbc_pkg::spbc_state_e state_ff;
   logic [2:0]            mask_ff;
   logic [2:0]            open_cmd_ff;
   logic                  close_cmd_ff;
   logic [15:0]           pulse_cnt_ff;
   logic [15:0]           term_cnt_ff;
   logic                  close_ok;
   logic                  open_done;
   logic                  term_hit;
   logic                  open_success;
   logic                  close_refused;
   logic                  busy_ignored;
   logic                  open_tmo;
   logic                  close_tmo;

   assign close_ok = (!ctrl_ff[`SPBC_CTRL_SYNC_EN] || sync_s) &&
                     (!ctrl_ff[`SPBC_CTRL_READY_EN] ||
                      (ready_s == ctrl_ff[`SPBC_CTRL_READY_HIGH]));

   assign close_refused = (state_ff == spbc_pkg::ST_IDLE) && (open_req == 3'h0) &&
                          close_req && !close_ok;
   assign busy_ignored  = (state_ff != spbc_pkg::ST_IDLE) && ((open_req != 3'h0) || close_req);
   assign open_done     = ((ph_open | ~mask_ff) == 3'h7);
   assign term_hit      = (term_cnt_ff >= term_ff);
   assign open_success  = (state_ff == spbc_pkg::ST_OPENING) && open_done;
   assign open_tmo      = (state_ff == spbc_pkg::ST_OPENING) && !open_done && term_hit;
   assign close_tmo     = (state_ff == spbc_pkg::ST_CLOSING) && (ph_closed != 3'h7) && term_hit;

   // Operation sequencing; open has priority over close
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= spbc_pkg::ST_IDLE;
         mask_ff  <= 3'h0;
      end else begin
         case (state_ff)
            spbc_pkg::ST_IDLE: begin
               if (open_req != 3'h0) begin
                  state_ff <= spbc_pkg::ST_OPENING;
                  mask_ff  <= open_req;
               end else if (close_req && close_ok) begin
                  state_ff <= spbc_pkg::ST_CLOSING;
               end
            end
            spbc_pkg::ST_OPENING: begin
               if (open_done || term_hit) begin
                  state_ff <= spbc_pkg::ST_IDLE;
               end
            end
            spbc_pkg::ST_CLOSING: begin
               if ((ph_closed == 3'h7) || term_hit) begin
                  state_ff <= spbc_pkg::ST_IDLE;
               end
            end
            default: state_ff <= spbc_pkg::ST_IDLE;
         endcase
      end
   end

   // Pulse and termination tick counters
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pulse_cnt_ff <= 16'h0000;
         term_cnt_ff  <= 16'h0000;
      end else if (state_ff == spbc_pkg::ST_IDLE) begin
         pulse_cnt_ff <= 16'h0000;
         term_cnt_ff  <= 16'h0000;
      end else if (tick) begin
         if (pulse_cnt_ff != 16'hffff) begin
            pulse_cnt_ff <= pulse_cnt_ff + 16'h0001;
         end
         if (term_cnt_ff != 16'hffff) begin
            term_cnt_ff <= term_cnt_ff + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         open_cmd_ff  <= 3'h0;
         close_cmd_ff <= 1'b0;
      end else begin
         case (state_ff)
            spbc_pkg::ST_IDLE: begin
               open_cmd_ff  <= open_req;
               close_cmd_ff <= (open_req == 3'h0) && close_req && close_ok;
            end
            spbc_pkg::ST_OPENING: begin
               open_cmd_ff  <= (open_done || term_hit || pulse_cnt_ff >= open_len_ff) ?
                               3'h0 : (open_cmd_ff & ~ph_open);
               close_cmd_ff <= 1'b0;
            end
            spbc_pkg::ST_CLOSING: begin
               open_cmd_ff  <= 3'h0;
               close_cmd_ff <= close_cmd_ff && (ph_closed != 3'h7) && !term_hit &&
                               (pulse_cnt_ff < close_len_ff);
            end
            default: begin
               open_cmd_ff  <= 3'h0;
               close_cmd_ff <= 1'b0;
            end
         endcase
      end
   end

   assign open_cmd_out  = open_cmd_ff;
   assign close_cmd_out = close_cmd_ff;

   // Registered event outputs; timeout lasts one cycle, refusal lasts as long as a refused close_req is held
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_timeout_event  <= 1'b0;
         close_refused_event <= 1'b0;
      end else begin
         ctrl_timeout_event  <= open_tmo || close_tmo;
         close_refused_event <= close_refused;
      end
   end

   // ==========================================================
   // Final trip output
   logic        ftrip_ff;
   logic [15:0] ftrip_cnt_ff;

   // zero length holds until next close
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ftrip_ff     <= 1'b0;
         ftrip_cnt_ff <= 16'h0000;
      end else if (open_success && !(ar_in_control && ar_reclose_expected)) begin
         ftrip_ff     <= 1'b1;
         ftrip_cnt_ff <= 16'h0000;
      end else if (close_cmd_ff) begin
         ftrip_ff <= 1'b0;
      end else if (ftrip_ff && ftrip_len_ff != 16'h0000) begin
         if (ftrip_cnt_ff >= ftrip_len_ff) begin
            ftrip_ff <= 1'b0;
         end else if (tick) begin
            ftrip_cnt_ff <= ftrip_cnt_ff + 16'h0001;
         end
      end
   end

   assign final_trip_out = ftrip_ff;

   // ==========================================================
   // Sticky events, write one to clear, set wins
   logic [3:0] ev_ff;
   logic [3:0] ev_set;
   logic [3:0] ev_clr;

   assign ev_set = {busy_ignored, close_refused, close_tmo, open_tmo};
   assign ev_clr = (reg_wr && reg_addr == `SPBC_OFS_EVENTS) ? reg_wdata[3:0] : 4'h0;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ev_ff <= 4'h0;
      end else begin
         ev_ff <= (ev_ff & ~ev_clr) | ev_set;
      end
   end

   // ==========================================================
   // Read data, valid only the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SPBC_OFS_CTRL:      reg_rdata <= {29'h0, ctrl_ff};
            `SPBC_OFS_TRAVERSE:  reg_rdata <= {16'h0, traverse_ff};
            `SPBC_OFS_CLOSE_LEN: reg_rdata <= {16'h0, close_len_ff};
            `SPBC_OFS_OPEN_LEN:  reg_rdata <= {16'h0, open_len_ff};
            `SPBC_OFS_TERM:      reg_rdata <= {16'h0, term_ff};
            `SPBC_OFS_FTRIP_LEN: reg_rdata <= {16'h0, ftrip_len_ff};
            `SPBC_OFS_STATUS:    reg_rdata <= {18'h0, state_ff, ftrip_ff, sync_s, ready_s,
                                              close_ok, cart_ff, phase_status};
            `SPBC_OFS_EVENTS:    reg_rdata <= {28'h0, ev_ff};
            default:             reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule : spbc_breaker_ctrl

`default_nettype wire

// ---- dv/spbc_breaker_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Breaker poles and their status contacts
module spbc_breaker_model (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [2:0] open_cmd,
   input  wire logic       close_cmd,
   input  wire logic [1:0] fault_mode,
   input  wire logic [7:0] move_delay,
   output logic      [2:0] open_contact,
   output logic      [2:0] close_contact
);
   logic [2:0] closed_ff;
   logic [2:0] target_ff;
   logic       to_close_ff;
   logic [7:0] cnt_ff;
   logic [2:0] mid;
   logic       start;

   // Move only toward a position not yet reached
   assign start = (open_cmd & closed_ff) != 3'h0 || (close_cmd && closed_ff != 3'h7);
   assign mid   = (cnt_ff != 8'h00) ? target_ff : 3'h0;

   // Poles travel move_delay cycles; stuck mode ignores the coils
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         closed_ff   <= 3'h0;
         target_ff   <= 3'h0;
         to_close_ff <= 1'b0;
         cnt_ff      <= 8'h00;
      end else if (cnt_ff != 8'h00) begin
         cnt_ff <= cnt_ff - 8'h01;
         if (cnt_ff == 8'h01) begin
            closed_ff <= to_close_ff ? 3'h7 : closed_ff & ~target_ff;
         end
      end else if (fault_mode != 2'h1 && start) begin
         target_ff   <= close_cmd ? ~closed_ff : open_cmd & closed_ff;
         to_close_ff <= close_cmd;
         cnt_ff      <= move_delay;
      end
   end

   // Travelling poles release both contacts; fault modes 2 and 3 force both
   assign open_contact  = fault_mode == 2'h2 ? 3'h7 :
                          fault_mode == 2'h3 ? 3'h0 : ~closed_ff & ~mid;
   assign close_contact = fault_mode == 2'h2 ? 3'h7 :
                          fault_mode == 2'h3 ? 3'h0 : closed_ff & ~mid;
endmodule : spbc_breaker_model

`default_nettype wire

// ---- dv/spbc_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checker
module spbc_ctrl_checker #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       close_req,
   input wire logic       ar_in_control,
   input wire logic       ar_reclose_expected,
   input wire logic [2:0] open_cmd_out,
   input wire logic       close_cmd_out,
   input wire logic       final_trip_out,
   input wire logic [5:0] phase_status,
   input wire logic       ctrl_timeout_event,
   input wire logic       close_refused_event
);
   // Default pulse length plus one tick of slack
   localparam int CAP = 21 * TICK_CYCLES + 2;
   logic [2:0]  ph_open;
   logic [31:0] run_ff;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Phases reported open
   assign ph_open = {phase_status[5:4] == 2'h1, phase_status[3:2] == 2'h1,
                     phase_status[1:0] == 2'h1};

   // Length of the running command pulse
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_ff <= 32'h0;
      end else begin
         run_ff <= (open_cmd_out != 3'h0 || close_cmd_out) ? run_ff + 32'h1 : 32'h0;
      end
   end

   // ==========================================================
   // Properties
   property p_excl; !(open_cmd_out != 3'h0 && close_cmd_out); endproperty
   a_excl: assert property (p_excl) else $error("open and close together");
   property p_close_end; close_cmd_out && phase_status == 6'h2a |=> !close_cmd_out; endproperty
   a_close_end: assert property (p_close_end) else $error("close held");
   property p_open_end;
      open_cmd_out != 3'h0 && (open_cmd_out & ~ph_open) == 3'h0 |=> open_cmd_out == 3'h0;
   endproperty
   a_open_end: assert property (p_open_end) else $error("open held");
   property p_refused; close_refused_event |-> $past(close_req) && !close_cmd_out; endproperty
   a_refused: assert property (p_refused) else $error("stray refusal");
   property p_tmo;
      ctrl_timeout_event |=> open_cmd_out == 3'h0 && !close_cmd_out && !ctrl_timeout_event;
   endproperty
   a_tmo: assert property (p_tmo) else $error("operation not ended");
   property p_ft_ar;
      $rose(final_trip_out) |-> !($past(ar_in_control) && $past(ar_reclose_expected));
   endproperty
   a_ft_ar: assert property (p_ft_ar) else $error("final trip, reclose due");
   property p_ft_cause;
      $rose(final_trip_out) |-> $past(open_cmd_out, 1) != 3'h0 ||
         $past(open_cmd_out, 2) != 3'h0 || $past(open_cmd_out, 3) != 3'h0;
   endproperty
   a_ft_cause: assert property (p_ft_cause) else $error("final trip, no open");
   property p_cap; run_ff <= 32'(CAP); endproperty
   a_cap: assert property (p_cap) else $error("pulse too long");
endmodule : spbc_ctrl_checker

bind spbc_breaker_ctrl spbc_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) i_spbc_ctrl_checker (
   .ref_clk, .rst, .close_req, .ar_in_control, .ar_reclose_expected, .open_cmd_out,
   .close_cmd_out, .final_trip_out, .phase_status, .ctrl_timeout_event, .close_refused_event);

`default_nettype wire

// ---- dv/single_pole_breaker_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench top
module single_pole_breaker_control_tb;
   logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        close_req = 1'b0, ready_in = 1'b0, sync_in = 1'b0;
   logic        cart_inserted_input = 1'b0, cart_removed_input = 1'b0;
   logic        ar_in_control = 1'b0, ar_reclose_expected = 1'b0;
   logic [7:0]  reg_addr = 8'h00, move_delay = 8'h10;
   logic [31:0] reg_wdata = 32'h0, rd_d;
   logic [2:0]  open_req = 3'h0;
   logic [1:0]  fault_mode = 2'h0;
   wire logic [31:0] reg_rdata;
   wire logic [2:0]  open_cmd_out, open_status_in, close_status_in;
   wire logic        close_cmd_out, final_trip_out, ctrl_timeout_event, close_refused_event;
   wire logic [5:0]  phase_status;
   wire logic [1:0]  cart_status;
   int fail_count = 0, compares = 0;

   // Clock, 4 ns period
   initial forever #2 ref_clk = ~ref_clk;

   spbc_breaker_ctrl #(.TICK_CYCLES(10)) i_spbc_breaker_ctrl (
      .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .open_status_in,
      .close_status_in, .cart_inserted_input, .cart_removed_input, .ready_in, .sync_in,
      .open_req, .close_req, .ar_in_control, .ar_reclose_expected, .open_cmd_out,
      .close_cmd_out, .final_trip_out, .phase_status, .cart_status, .ctrl_timeout_event,
      .close_refused_event);

   spbc_breaker_model i_spbc_breaker_model (
      .ref_clk, .rst, .open_cmd(open_cmd_out), .close_cmd(close_cmd_out), .fault_mode,
      .move_delay, .open_contact(open_status_in), .close_contact(close_status_in));

   // ==========================================================
   // Common tasks
   task automatic end_sim;
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic sel(input int k);
      case (k)
         0: return |open_cmd_out;
         1: return close_cmd_out;
         2: return final_trip_out;
         3: return ctrl_timeout_event;
         default: return close_refused_event;
      endcase
   endfunction : sel

   task automatic wait_for(input int k, input logic v, input int n);
      int i = 0;
      #1;
      while (sel(k) !== v && i < n) begin
         @(posedge ref_clk);
         #1;
         i++;
      end
      if (i >= n) begin
         fail_count++;
         $display("MISMATCH %0t wait %0d timed out", $time, k);
         end_sim();
      end
   endtask : wait_for

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic req(input logic [2:0] o, input logic c);
      @(posedge ref_clk);
      open_req  <= o;
      close_req <= c;
      @(posedge ref_clk);
      open_req  <= 3'h0;
      close_req <= 1'b0;
   endtask : req

   // ==========================================================
   // Scenarios
   task automatic t_regs;
      for (int i = 0; i < 5; i++) begin
         rd(8'(4 + 4 * i), rd_d);
         chk(rd_d, i == 3 ? 32'h3e8 : 32'h14);
      end
      rd(8'h20, rd_d);
      chk(rd_d, 32'h0);
      wr(8'h10, 32'h1e);
      rd(8'h10, rd_d);
      chk(rd_d, 32'h1e);
   endtask : t_regs

   task automatic t_close;
      req(3'h0, 1'b1);
      wait_for(1, 1'b1, 4);
      wait_for(1, 1'b0, 300);
      chk(32'(phase_status), 32'h2a);
      chk(32'(final_trip_out), 32'h0);
   endtask : t_close

   task automatic t_open_a;
      req(3'h1, 1'b0);
      wait_for(0, 1'b1, 4);
      chk(32'(open_cmd_out), 32'h1);
      req(3'h6, 1'b1);
      wait_for(0, 1'b0, 300);
      chk(32'(phase_status), 32'h29);
      wait_for(2, 1'b1, 4);
      settle(180);
      chk(32'(final_trip_out), 32'h1);
      wait_for(2, 1'b0, 40);
      rd(8'h1c, rd_d);
      chk(rd_d, 32'h8);
      wr(8'h1c, 32'hf);
      rd(8'h1c, rd_d);
      chk(rd_d, 32'h0);
   endtask : t_open_a

   task automatic t_open_ar;
      @(posedge ref_clk);
      ar_in_control       <= 1'b1;
      ar_reclose_expected <= 1'b1;
      move_delay          <= 8'h60;
      req(3'h7, 1'b0);
      wait_for(0, 1'b1, 4);
      chk(32'(open_cmd_out), 32'h7);
      wait_for(0, 1'b0, 300);
      settle(10);
      chk(32'(phase_status), 32'h15);
      chk(32'(final_trip_out), 32'h0);
      @(posedge ref_clk);
      ar_in_control       <= 1'b0;
      ar_reclose_expected <= 1'b0;
      move_delay          <= 8'h10;
   endtask : t_open_ar

   task automatic t_gating;
      wr(8'h00, 32'h1);
      req(3'h0, 1'b1);
      wait_for(4, 1'b1, 4);
      chk(32'(close_cmd_out), 32'h0);
      rd(8'h1c, rd_d);
      chk(rd_d, 32'h4);
      wr(8'h1c, 32'hf);
      wr(8'h00, 32'h6);
      req(3'h0, 1'b1);
      ready_in <= 1'b1;
      sync_in  <= 1'b1;
      wait_for(4, 1'b1, 4);
      wr(8'h1c, 32'hf);
      wr(8'h00, 32'h7);
      settle(8);
      t_close();
   endtask : t_gating

   task automatic t_ft_zero;
      wr(8'h14, 32'h0);
      req(3'h7, 1'b0);
      wait_for(0, 1'b1, 4);
      wait_for(0, 1'b0, 300);
      wait_for(2, 1'b1, 4);
      settle(300);
      chk(32'(final_trip_out), 32'h1);
      t_close();
   endtask : t_ft_zero

   task automatic t_timeout(input logic [2:0] o, input logic c, input logic [31:0] m);
      fault_mode <= 2'h1;
      req(o, c);
      wait_for(c ? 1 : 0, 1'b1, 4);
      settle(180);
      chk(32'(sel(c ? 1 : 0)), 32'h1);
      wait_for(c ? 1 : 0, 1'b0, 40);
      wait_for(3, 1'b1, 150);
      rd(8'h1c, rd_d);
      chk(rd_d, m);
      wr(8'h1c, 32'hf);
      fault_mode <= 2'h0;
   endtask : t_timeout

   task automatic t_status;
      @(posedge ref_clk);
      fault_mode <= 2'h2;
      settle(100);
      chk(32'(phase_status == 6'h3f), 32'h0);
      settle(150);
      chk(32'(phase_status), 32'h3f);
      fault_mode <= 2'h3;
      settle(250);
      chk(32'(phase_status), 32'h0);
      @(posedge ref_clk);
      cart_inserted_input <= 1'b1;
      settle(8);
      chk(32'(cart_status), 32'h2);
      @(posedge ref_clk);
      cart_inserted_input <= 1'b0;
      cart_removed_input  <= 1'b1;
      settle(8);
      chk(32'(cart_status), 32'h1);
      fault_mode <= 2'h0;
   endtask : t_status

   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      settle(10);
      chk(32'(phase_status), 32'h15);
      t_close();
      t_open_a();
      t_close();
      t_open_ar();
      t_gating();
      t_ft_zero();
      t_timeout(3'h7, 1'b0, 32'h1);
      req(3'h7, 1'b0);
      wait_for(0, 1'b1, 4);
      wait_for(0, 1'b0, 300);
      t_timeout(3'h0, 1'b1, 32'h2);
      t_status();
      end_sim();
   end
endmodule : single_pole_breaker_control_tb

`default_nettype wire
